// *** hdl/rxo_top.sv ***
/*
 * receive output path: elastic buffer, squelch, polarity, clock
 * substitute, pattern generator and checker, avalon-mm registers.
 * assumes all line inputs are asynchronous pins and the bus master
 * runs on CLOCK.
 */
// Register access over Avalon-MM was chosen for this implementation.
// What this block does
// - output polarity flip inverts the data output
// - loss of signal substitutes clock when enabled
// - lock loss squelches output when enabled
// - signal loss squelches output when enabled
// - forced squelch silences output unconditionally
// - auto clear resets buffer on errors
// - any clear zeroes buffer, pointer centred
// - checker polarity flip inverts checked data
// - checker mode: off, prbs7, prbs31, user
// - generator polarity flip inverts generated pattern
// - generator mode: off, prbs7, prbs31, user
// - prbs31 emitted and expected in inverted form
// - user pattern eight bytes, sent lsb first
`timescale 1ns/1ns
`include "rxo_cfg.svh"

module rxo_top #(
    parameter int DEPTH = 16
) (
    input  wire  logic              CLOCK,
    input  wire  logic              RST_N,
    input  wire  rxo_pkg::rxo_addr_t AVS_ADDRESS,
    input  wire  logic              AVS_READ,
    input  wire  logic              AVS_WRITE,
    input  wire  rxo_pkg::rxo_word_t AVS_WRITEDATA,
    input  wire  rxo_pkg::rxo_be_t  AVS_BYTEENABLE,
    output rxo_pkg::rxo_word_t      AVS_READDATA,
    output logic                    AVS_WAITREQUEST,
    input  wire  logic              RX_DATA,
    input  wire  logic              RX_VALID,
    input  wire  logic              RX_LOS,
    input  wire  logic              RX_LOL,
    input  wire  logic              RD_TAKE,
    output logic                    RD_DATA,
    output logic                    RD_SQUELCH,
    output logic                    IRQ
);
    import rxo_pkg::*;

    localparam int PW = $clog2(DEPTH) + 1;
    localparam logic [PW-1:0] CENTER = PW'(DEPTH / 2);

    rxo_line_s              sync1, sync2, line_q;
    rxo_path_s              path, next_path;
    rxo_tpsel_s             tpsel, next_tpsel;
    logic [63:0]            ptn, next_ptn;
    logic [`RXO_ST_W-1:0]   stat, next_stat, mask, next_mask, ev;
    logic                   ack, next_ack;
    rxo_word_t              rdata, next_rdata;
    logic [5:0]             idx;
    logic                   bus_req, wr_now;
    logic [DEPTH-1:0]       fmem, next_fmem;
    logic [PW-1:0]          fcnt, next_fcnt;
    logic                   ovf, unf, fclear, head;
    logic [30:0]            gsr, next_gsr, csr, next_csr;
    logic [5:0]             gidx, next_gidx, cidx, next_cidx;
    logic                   gen_on, gen_bit, chk_on, chk_bit, chk_exp, chk_err;
    logic [15:0]            errcnt, next_errcnt;
    logic                   squelch_now, sub_now, src_bit, tog, next_tog;
    logic                   next_rd_data, next_rd_squelch;

    // three flip-flops on every line input pin; only sync2 and line_q are read
    always_ff @(posedge CLOCK) begin
        sync1  <= '{RX_DATA, RX_VALID, RX_LOS, RX_LOL, RD_TAKE};
        sync2  <= sync1;
        line_q <= sync2;
    end

    // bus decode; the answer comes one cycle after the request
    assign idx             = AVS_ADDRESS[7:2];
    assign bus_req         = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = bus_req & ~ack;
    assign wr_now          = AVS_WRITE & ack & AVS_BYTEENABLE[0];
    assign AVS_READDATA    = rdata;
    assign IRQ             = |(stat & mask);

    // line events: buffer overflow or underflow, rising edges of loss indications and checker mismatches
    assign ev[`RXO_ST_FIFO] = ovf | unf;
    assign ev[`RXO_ST_LOS]  = sync2.los & ~line_q.los;
    assign ev[`RXO_ST_LOL]  = sync2.lol & ~line_q.lol;
    assign ev[`RXO_ST_CHK]  = chk_err;

    // register file next state
    always_comb begin
        next_ack   = bus_req & ~ack;
        next_rdata = '0;
        next_path  = path;
        next_tpsel = tpsel;
        next_ptn   = ptn;
        next_mask  = mask;
        next_stat  = stat;
        if (bus_req && !ack) begin
            if (idx == `RXO_IDX_PATH) begin
                next_rdata[6:0] = path[6:0];
            end else if (idx == `RXO_IDX_TPSEL) begin
                next_rdata[7:0] = tpsel;
            end else if (idx >= `RXO_IDX_PTN0 && idx < `RXO_IDX_PTN0 + 6'h08) begin
                next_rdata[7:0] = ptn[8 * 32'(idx - `RXO_IDX_PTN0) +: 8];
            end else if (idx == `RXO_IDX_STAT) begin
                next_rdata[`RXO_ST_W-1:0] = stat;
            end else if (idx == `RXO_IDX_MASK) begin
                next_rdata[`RXO_ST_W-1:0] = mask;
            end else if (idx == `RXO_IDX_ERRCNT) begin
                next_rdata[15:0] = errcnt;
            end
        end
        if (wr_now) begin
            if (idx == `RXO_IDX_PATH) begin
                next_path     = AVS_WRITEDATA[7:0];
                next_path.rsv = 1'b0;
            end else if (idx == `RXO_IDX_TPSEL) begin
                next_tpsel = AVS_WRITEDATA[7:0];
            end else if (idx >= `RXO_IDX_PTN0 && idx < `RXO_IDX_PTN0 + 6'h08) begin
                next_ptn[8 * 32'(idx - `RXO_IDX_PTN0) +: 8] = AVS_WRITEDATA[7:0];
            end else if (idx == `RXO_IDX_STAT) begin
                next_stat = stat & ~AVS_WRITEDATA[`RXO_ST_W-1:0];
            end else if (idx == `RXO_IDX_MASK) begin
                next_mask = AVS_WRITEDATA[`RXO_ST_W-1:0];
            end
        end
        // a new event beats a software clear
        next_stat = next_stat | ev;
        // auto clear wipes the buffer error flag instead of raising it
        if (path.elastic_buffer_auto_clear) begin
            next_stat[`RXO_ST_FIFO] = 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ack   <= 1'b0;
            rdata <= '0;
            path  <= `RXO_PATH_RST;
            tpsel <= `RXO_TPSEL_RST;
            ptn   <= `RXO_PTN_RST;
            stat  <= '0;
            mask  <= '0;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
            path  <= next_path;
            tpsel <= next_tpsel;
            ptn   <= next_ptn;
            stat  <= next_stat;
            mask  <= next_mask;
        end
    end

    // elastic buffer, one bit wide; the head is bit 0
    assign ovf    = line_q.valid & (fcnt == PW'(DEPTH)) & ~line_q.take;
    assign unf    = line_q.take & (fcnt == '0);
    assign fclear = path.elastic_buffer_manual_clear
                  | (path.elastic_buffer_auto_clear & (ovf | unf));
    assign head   = fmem[0];

    always_comb begin
        next_fmem = fmem;
        next_fcnt = fcnt;
        if (fclear) begin
            next_fmem = '0;
            next_fcnt = CENTER;
        end else begin
            if (line_q.take && fcnt != '0) begin
                next_fmem = fmem >> 1;
                next_fcnt = fcnt - PW'(1);
            end
            if (line_q.valid && next_fcnt != PW'(DEPTH)) begin
                next_fmem[next_fcnt[PW-2:0]] = line_q.data;
                next_fcnt = next_fcnt + PW'(1);
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            fmem <= '0;
            fcnt <= CENTER;
        end else begin
            fmem <= next_fmem;
            fcnt <= next_fcnt;
        end
    end

    // generator; a disabled generator reseeds, so prbs7 after prbs31
    // needs the off step to avoid a dead all-zero low window
    assign gen_on = tpsel.generator_mode_select inside {`RXO_MODE_PRBS7, `RXO_MODE_PRBS31,
                                                         `RXO_MODE_USER};
    always_comb begin
        next_gsr  = gsr;
        next_gidx = gidx;
        gen_bit   = 1'b0;
        unique case (tpsel.generator_mode_select)
            `RXO_MODE_PRBS7:  gen_bit = gsr[6] ^ gsr[5];
            `RXO_MODE_PRBS31: gen_bit = ~(gsr[30] ^ gsr[27]);
            `RXO_MODE_USER:   gen_bit = ptn[gidx];
            default:          gen_bit = 1'b0;
        endcase
        if (!gen_on) begin
            next_gsr  = `RXO_LFSR_SEED;
            next_gidx = '0;
        end else if (line_q.take) begin
            next_gsr  = {gsr[29:0], gsr[6] ^ gsr[5]};
            if (tpsel.generator_mode_select == `RXO_MODE_PRBS31) begin
                next_gsr[0] = gsr[30] ^ gsr[27];
            end
            next_gidx = gidx + 6'h01;
        end
        gen_bit = gen_bit ^ tpsel.generator_polarity_flip;
    end

    // checker; prbs modes self-synchronise on the received history, user mode steps from bit 0 once enabled
    assign chk_on  = tpsel.checker_mode_select inside {`RXO_MODE_PRBS7, `RXO_MODE_PRBS31,
                                                        `RXO_MODE_USER};
    assign chk_bit = line_q.data ^ tpsel.checker_polarity_flip;
    assign chk_err = chk_on & line_q.valid & (chk_bit != chk_exp);
    always_comb begin
        next_csr    = csr;
        next_cidx   = cidx;
        next_errcnt = errcnt;
        chk_exp     = 1'b0;
        unique case (tpsel.checker_mode_select)
            `RXO_MODE_PRBS7:  chk_exp = csr[6] ^ csr[5];
            `RXO_MODE_PRBS31: chk_exp = ~(csr[30] ^ csr[27]);
            `RXO_MODE_USER:   chk_exp = ptn[cidx];
            default:          chk_exp = 1'b0;
        endcase
        if (!chk_on) begin
            next_cidx = '0;
        end else if (line_q.valid) begin
            // history holds the raw sequence, inversion undone
            next_csr  = {csr[29:0], tpsel.checker_mode_select == `RXO_MODE_PRBS31 ? ~chk_bit : chk_bit};
            next_cidx = cidx + 6'h01;
            if (chk_err && errcnt != 16'hffff) begin
                next_errcnt = errcnt + 16'h0001;  // saturates
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            gsr    <= `RXO_LFSR_SEED;
            gidx   <= '0;
            csr    <= '0;
            cidx   <= '0;
            errcnt <= '0;
        end else begin
            gsr    <= next_gsr;
            gidx   <= next_gidx;
            csr    <= next_csr;
            cidx   <= next_cidx;
            errcnt <= next_errcnt;
        end
    end

    // output stage: squelch beats clock substitute, which beats data
    assign squelch_now = path.squelch_force
                       | (path.squelch_on_lock_loss & line_q.lol)
                       | (path.squelch_on_signal_loss & line_q.los);
    assign sub_now     = path.clock_substitute_on_signal_loss & line_q.los;
    assign src_bit     = gen_on ? gen_bit : head;
    always_comb begin
        next_tog        = sub_now ? ~tog : 1'b0;  // half period is one cycle
        next_rd_squelch = squelch_now;
        if (squelch_now) begin
            next_rd_data = 1'b0;
        end else if (sub_now) begin
            next_rd_data = tog ^ path.data_flip;
        end else begin
            next_rd_data = src_bit ^ path.data_flip;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            tog        <= 1'b0;
            RD_DATA    <= 1'b0;
            RD_SQUELCH <= 1'b0;
        end else begin
            tog        <= next_tog;
            RD_DATA    <= next_rd_data;
            RD_SQUELCH <= next_rd_squelch;
        end
    end

    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    a_flip_data: assert property (!squelch_now && !sub_now && path.data_flip |=> RD_DATA == !$past(src_bit))
        else $error("flipped data wrong");
    a_clk_substitute: assert property ((sub_now && !squelch_now) [*3] |-> RD_DATA != $past(RD_DATA))
        else $error("substitute clock not toggling");
    a_squelch_lock: assert property (path.squelch_on_lock_loss && line_q.lol |=> RD_SQUELCH && !RD_DATA)
        else $error("lock loss not squelched");
    a_squelch_signal: assert property (path.squelch_on_signal_loss && line_q.los |=> RD_SQUELCH && !RD_DATA)
        else $error("signal loss not squelched");
    a_squelch_force: assert property (path.squelch_force |=> RD_SQUELCH ##0 !RD_DATA)
        else $error("forced squelch ignored");
    a_auto_clear: assert property (path.elastic_buffer_auto_clear && (ovf || unf)
                                   |=> fcnt == CENTER && !stat[`RXO_ST_FIFO])
        else $error("auto clear failed");
    a_no_auto: assert property (!path.elastic_buffer_auto_clear && !path.elastic_buffer_manual_clear && ovf
                                |=> stat[`RXO_ST_FIFO] && fcnt == PW'(DEPTH))
        else $error("buffer cleared without auto");
    a_manual_clear: assert property (path.elastic_buffer_manual_clear |=> fcnt == CENTER && fmem == '0)
        else $error("manual clear failed");
    a_checker_flag: assert property (chk_err |=> stat[`RXO_ST_CHK] && errcnt != 16'h0000)
        else $error("checker mismatch lost");
    a_checker_off: assert property (tpsel.checker_mode_select == `RXO_MODE_OFF || tpsel.checker_mode_select[2]
                                    |-> !chk_err)
        else $error("disabled checker reported");
    a_gen_prbs31: assert property (tpsel.generator_mode_select == `RXO_MODE_PRBS31 && !tpsel.generator_polarity_flip
                                   |-> gen_bit == !(gsr[30] ^ gsr[27]))
        else $error("prbs31 not inverted");
    a_gen_flip: assert property (gen_on && $stable(gsr) && $stable(gidx) && $rose(tpsel.generator_polarity_flip)
                                 && $stable(tpsel.generator_mode_select) |-> gen_bit != $past(gen_bit))
        else $error("generator flip ignored");
    a_user_order: assert property (tpsel.generator_mode_select == `RXO_MODE_USER && line_q.take
                                   |=> gidx == $past(gidx) + 6'h01)
        else $error("user pattern order broken");
    a_bad_mode: assert property (tpsel.generator_mode_select[2] |=> gsr == `RXO_LFSR_SEED)
        else $error("reserved mode active");
    a_reserved_zero: assert property (bus_req && !ack && idx == `RXO_IDX_PATH |=> !rdata[7])
        else $error("reserved bit reads one");
    a_bus_answer: assert property (bus_req |-> ##[0:1] !AVS_WAITREQUEST)
        else $error("bus answer late");

    c_squelch: cover property (path.squelch_on_signal_loss && line_q.los ##1 RD_SQUELCH);
    c_substitute: cover property (sub_now [*4]);
    c_auto_clear: cover property (path.elastic_buffer_auto_clear && ovf);
    c_checker_err: cover property (chk_err && IRQ);
endmodule

// *** inc/rxo_cfg.svh ***
/*
 * constants of the receive output path: register indices, reset values,
 * status bit positions, mode codes and timing.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef RXO_CFG_SVH
`define RXO_CFG_SVH

// register indices; byte address is four times the index
`define RXO_IDX_PATH    6'h1c
`define RXO_IDX_TPSEL   6'h1d
`define RXO_IDX_PTN0    6'h1f
`define RXO_IDX_STAT    6'h27
`define RXO_IDX_MASK    6'h28
`define RXO_IDX_ERRCNT  6'h29

// reset values
`define RXO_PATH_RST    8'h00
`define RXO_TPSEL_RST   8'h00
`define RXO_PTN_RST     64'haaaa_aaaa_aaaa_aaaa
`define RXO_LFSR_SEED   31'h7fff_ffff

// status and mask bit positions
`define RXO_ST_FIFO     0
`define RXO_ST_LOS      1
`define RXO_ST_LOL      2
`define RXO_ST_CHK      3
`define RXO_ST_W        4

// generator and checker mode codes
`define RXO_MODE_OFF    3'h0
`define RXO_MODE_PRBS7  3'h1
`define RXO_MODE_PRBS31 3'h2
`define RXO_MODE_USER   3'h3

// substitute clock: half period in cycles, at least one
`define RXO_CLK_MHZ     250
`define RXO_SUB_MHZ     622
`define RXO_SUB_HALF    ((`RXO_CLK_MHZ / (2 * `RXO_SUB_MHZ)) < 1 ? 1 : (`RXO_CLK_MHZ / (2 * `RXO_SUB_MHZ)))

`endif

// *** inc/rxo_pkg.sv ***
/*
 * types of the receive output path.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package rxo_pkg;
    typedef logic [7:0]  rxo_addr_t;
    typedef logic [31:0] rxo_word_t;
    typedef logic [3:0]  rxo_be_t;
    typedef logic [2:0]  rxo_mode_t;

    // output path configuration, bit 7 first
    typedef struct packed {
        logic rsv;
        logic data_flip;
        logic clock_substitute_on_signal_loss;
        logic squelch_on_lock_loss;
        logic squelch_on_signal_loss;
        logic squelch_force;
        logic elastic_buffer_auto_clear;
        logic elastic_buffer_manual_clear;
    } rxo_path_s;

    // test pattern selection, bit 7 first
    typedef struct packed {
        logic      checker_polarity_flip;
        rxo_mode_t checker_mode_select;
        logic      generator_polarity_flip;
        rxo_mode_t generator_mode_select;
    } rxo_tpsel_s;

    // synchronised line inputs
    typedef struct packed {
        logic data;
        logic valid;
        logic los;
        logic lol;
        logic take;
    } rxo_line_s;
endpackage

// *** sim/rxo_host.sv ***
/*
 * far side model: host deserializer that takes retimed bits.
 * assumes pace is driven by the bench on the rising edge.
 */
`timescale 1ns/1ns
module rxo_host (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [1:0] pace,
    output logic            rd_take
);
    logic ph;
    // pace 1 takes every cycle, pace 2 every other cycle, 0 stalls
    always @(posedge clock) begin
        if (!rst_n) begin
            ph      <= 1'b0;
            rd_take <= 1'b0;
        end else begin
            ph      <= ~ph;
            rd_take <= (pace == 2'd1) || (pace == 2'd2 && ph);
        end
    end
endmodule

// *** sim/rxo_top_tb_top.sv ***
/*
 * self-checking bench of the receive output path.
 * assumes rxo_pkg is compiled first and rxo_host is present.
 */
`timescale 1ns/1ns
module rxo_top_tb_top;
    import rxo_pkg::*;
    logic       clock = 0, rst_n = 0, avs_read = 0, avs_write = 0;
    logic       rx_data = 0, rx_valid = 0, rx_los = 0, rx_lol = 0;
    logic [1:0] pace = 0;
    rxo_addr_t  avs_address = '0;
    rxo_word_t  avs_writedata = '0, avs_readdata, rd, v;
    rxo_be_t    avs_byteenable = 4'hf;
    logic       avs_waitrequest, rd_take, rd_data, rd_squelch, irq;
    int         num_errors = 0, tests_run = 0, seed = 32, any;
    logic       cap [0:127];
    logic [63:0] ptn;
    logic [3:0] sq [0:5] = '{4'h1, 4'h0, 4'h5, 4'h0, 4'h3, 4'h0};
    logic [7:0] sqc [0:5] = '{8'h04, 8'h00, 8'h08, 8'h08, 8'h10, 8'h10};

    always #2 clock = ~clock;

    rxo_top #(.DEPTH(4)) dut (
        .CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .RX_DATA(rx_data),
        .RX_VALID(rx_valid), .RX_LOS(rx_los), .RX_LOL(rx_lol), .RD_TAKE(rd_take),
        .RD_DATA(rd_data), .RD_SQUELCH(rd_squelch), .IRQ(irq)
    );
    rxo_host host (.clock(clock), .rst_n(rst_n), .pace(pace), .rd_take(rd_take));

    task summarize;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task check(input string name, input rxo_word_t exp, input rxo_word_t got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one bus cycle; request held until waitrequest is seen low at an edge
    // no local limit: only the watchdog ends a wait
    task bus(input logic is_wr, input rxo_addr_t a, input rxo_word_t d, output rxo_word_t q);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        if (is_wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task wr(input rxo_addr_t a, input rxo_word_t d);
        rxo_word_t q;
        bus(1'b1, a, d, q);
    endtask

    task reg_chk(input rxo_addr_t a, input rxo_word_t exp);
        rxo_word_t q;
        bus(1'b0, a, 32'h0000_0000, q);
        check("register", exp, q);
    endtask

    task capture(input int n);
        repeat (8) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            cap[i] = rd_data;
        end
    endtask

    // captured stream is some rotation of the pattern, lsb sent first
    function automatic int is_rot(input logic [63:0] p, input logic inv);
        for (int r = 0; r < 64; r++) begin
            int ok;
            ok = 1;
            for (int i = 0; i < 64; i++) if (cap[i] !== (p[(i + r) % 64] ^ inv)) ok = 0;
            if (ok == 1) return 1;
        end
        return 0;
    endfunction

    // stream obeys the feedback recurrence; inv flags an inverted sequence
    function automatic int lfsr_ok(input int a, input int b, input logic inv);
        for (int i = b; i < 128; i++) if (cap[i] !== (cap[i - a] ^ cap[i - b] ^ inv)) return 0;
        return 1;
    endfunction

    function automatic int all_zero(input int n);
        for (int i = 0; i < n; i++) if (cap[i] !== 1'b0) return 0;
        return 1;
    endfunction

    initial begin
        #200000;
        num_errors++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        reg_chk(8'h70, 32'h0000_0000);
        reg_chk(8'h74, 32'h0000_0000);
        reg_chk(8'h7c, 32'h0000_00aa);
        reg_chk(8'hfc, 32'h0000_0000);
        // random selections, always through disabled so prbs31 never goes straight to prbs7
        repeat (4) begin
            v = $random(seed) & 32'h0000_00ff;
            wr(8'h74, 32'h0000_0000);
            wr(8'h74, v);
            reg_chk(8'h74, v);
        end
        wr(8'h70, 32'h0000_0080);
        reg_chk(8'h70, 32'h0000_0000);
        ptn = {$random(seed), $random(seed)};
        for (int i = 0; i < 8; i++) wr(rxo_addr_t'(8'h7c + 4 * i), {24'h0, ptn[8 * i +: 8]});
        pace <= 2'd1;
        wr(8'h74, 32'h0000_0000);
        wr(8'h74, 32'h0000_0003);
        capture(64);
        check("user pattern", 1, is_rot(ptn, 1'b0));
        // host stalls so the flip lands on a frozen generator state
        pace <= 2'd0;
        repeat (6) @(posedge clock);
        wr(8'h74, 32'h0000_000b);
        pace <= 2'd1;
        capture(64);
        check("generator flip", 1, is_rot(ptn, 1'b1));
        wr(8'h74, 32'h0000_0003);
        wr(8'h70, 32'h0000_0040);
        capture(64);
        check("output flip", 1, is_rot(ptn, 1'b1));
        wr(8'h70, 32'h0000_0000);
        wr(8'h74, 32'h0000_0002);
        capture(128);
        check("prbs31", 1, lfsr_ok(3, 31, 1'b1) | lfsr_ok(28, 31, 1'b1));
        wr(8'h74, 32'h0000_0000);
        wr(8'h74, 32'h0000_0001);
        capture(128);
        check("prbs7", 1, lfsr_ok(6, 7, 1'b0) | lfsr_ok(1, 7, 1'b0));
        wr(8'h74, 32'h0000_0009);
        capture(128);
        check("prbs7 flip", 1, lfsr_ok(6, 7, 1'b1) | lfsr_ok(1, 7, 1'b1));
        // an all-zero stream fits the prbs7 recurrence; flipped it never does
        rx_valid <= 1'b1;
        wr(8'h74, 32'h0000_0010);
        repeat (60) @(posedge clock);
        bus(1'b0, 8'ha4, 32'h0000_0000, rd);
        repeat (40) @(posedge clock);
        reg_chk(8'ha4, 32'h0000_0000);
        wr(8'h74, 32'h0000_0090);
        repeat (40) @(posedge clock);
        bus(1'b0, 8'ha4, 32'h0000_0000, v);
        check("checker flip", 1, v > rd);
        // flipped zeros are all ones, the inverted prbs31 form of an all-zero history
        wr(8'h74, 32'h0000_00a0);
        repeat (60) @(posedge clock);
        bus(1'b0, 8'ha4, 32'h0000_0000, rd);
        repeat (40) @(posedge clock);
        reg_chk(8'ha4, rd);
        for (int m = 4; m < 8; m++) begin
            wr(8'h74, m);
            capture(16);
            check("unused code", 1, all_zero(16));
        end
        wr(8'h74, 32'h0000_0000);
        // squelch table: enable, signal loss, lock loss, expected
        for (int i = 0; i < 6; i++) begin
            wr(8'h70, sqc[i]);
            rx_los <= sq[i][2];
            rx_lol <= sq[i][1];
            repeat (8) @(posedge clock);
            check("squelch", sq[i][0], rd_squelch);
            if (sq[i][0]) check("squelched data", 0, rd_data);
        end
        rx_los <= 1'b0;
        rx_lol <= 1'b0;
        wr(8'h70, 32'h0000_0000);
        wr(8'h9c, 32'h0000_000f);
        wr(8'ha0, 32'h0000_0002);
        @(posedge clock);
        check("irq idle", 0, irq);
        rx_los <= 1'b1;
        repeat (8) @(posedge clock);
        check("irq raised", 1, irq);
        wr(8'ha0, 32'h0000_0000);
        @(posedge clock);
        check("irq masked", 0, irq);
        wr(8'ha0, 32'h0000_0002);
        wr(8'h9c, 32'h0000_0002);
        repeat (2) @(posedge clock);
        check("irq cleared", 0, irq);
        wr(8'h70, 32'h0000_0020);
        capture(16);
        any = 0;
        for (int i = 1; i < 16; i++) if (cap[i] === cap[i - 1]) any = 1;
        check("clock substitute", 0, any);
        rx_los <= 1'b0;
        wr(8'h70, 32'h0000_0000);
        // host stalls so the buffer overflows
        pace <= 2'd0;
        repeat (20) @(posedge clock);
        bus(1'b0, 8'h9c, 32'h0000_0000, rd);
        check("buffer error", 1, rd[0]);
        wr(8'h70, 32'h0000_0002);
        wr(8'h9c, 32'h0000_0001);
        pace <= 2'd2;
        repeat (20) @(posedge clock);
        bus(1'b0, 8'h9c, 32'h0000_0000, rd);
        check("auto clear", 0, rd[0]);
        // fill the buffer with ones so the head shows a one before the clear
        rx_data <= 1'b1;
        wr(8'h70, 32'h0000_0000);
        pace <= 2'd1;
        repeat (16) @(posedge clock);
        check("buffer data", 1, rd_data);
        pace <= 2'd0;
        repeat (10) @(posedge clock);
        check("buffer held", 1, rd_data);
        wr(8'h70, 32'h0000_0001);
        rx_valid <= 1'b0;
        repeat (6) @(posedge clock);
        wr(8'h70, 32'h0000_0000);
        capture(2);
        check("manual clear", 1, all_zero(2));
        summarize();
    end
endmodule
